// ---- hdl/trim_regs_pkg.sv ----
// Package for the converter trim register bank: addresses, fields, resets.
// Assumes a single serial write port and a system clock domain.
package trim_regs_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS      = 32;
    localparam logic [11:0] FRAME_HEADER    = 12'h001;
    localparam int          HDR_MSB         = 31;
    localparam int          HDR_LSB         = 20;
    localparam int          ADDR_MSB        = 19;
    localparam int          ADDR_LSB        = 16;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [3:0]  ADDR_CH1_OFFSET = 4'h2;
    localparam logic [3:0]  ADDR_CH1_GAIN   = 4'h3;
    localparam logic [3:0]  ADDR_CH2_OFFSET = 4'hA;
    localparam logic [3:0]  ADDR_CH2_GAIN   = 4'hB;
    localparam logic [3:0]  ADDR_ILV_ENABLE = 4'hD;
    localparam logic [3:0]  ADDR_ILV_COARSE = 4'hE;
    localparam logic [3:0]  ADDR_ILV_FINE   = 4'hF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          OFS_MAG_MSB     = 15;
    localparam int          OFS_MAG_LSB     = 8;
    localparam int          OFS_SIGN_BIT    = 7;
    localparam int          GAIN_MSB        = 15;
    localparam int          GAIN_LSB        = 7;
    localparam int          ILV_ON_BIT      = 15;
    localparam int          AUTO_PHASE_BIT  = 14;
    localparam int          INPUT_SEL_BIT   = 15;
    localparam int          SKEW_SEL_BIT    = 14;
    localparam int          COARSE_MSB      = 13;
    localparam int          COARSE_LSB      = 11;
    localparam int          FINE_MSB        = 15;
    localparam int          FINE_LSB        = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_OFFSET      = 16'h007F;
    localparam logic [15:0] RST_GAIN        = 16'h807F;
    localparam logic [15:0] RST_ILV_ENABLE  = 16'h3FFF;
    localparam logic [15:0] RST_ILV_COARSE  = 16'h07FF;
    localparam logic [15:0] RST_ILV_FINE    = 16'h007F;

    // ------------------------------------------------------------------
    // Crossing
    // ------------------------------------------------------------------
    localparam int          SYNC_STAGES     = 2;

endpackage

// ---- hdl/frame_shifter.sv ----
// Serial-clock side: shifts 32-bit write frames and hands each out.
// Assumes serial_clk_i is the host's clock; it may stop between frames.
`timescale 1ns/1ps
module frame_shifter
    import trim_regs_pkg::*;
(
    input  wire logic        serial_clk_i,      // Link clock from host
    input  wire logic        serial_select_n_i, // Frame select, low active
    input  wire logic        serial_write_input_i, // Serial data, MSB first
    output logic [31:0]      frame_word_o,      // Last complete frame
    output logic             frame_toggle_o     // Flips once per frame
);

    // ------------------------------------------------------------------
    // Shift state
    // ------------------------------------------------------------------
    // Power-up values stand in the declarations: this clock may never
    // run and has no reset, and a count left unknown would never end.
    logic [30:0] shift     = 31'h0000_0000; // First 31 bits so far
    logic [4:0]  bit_count = 5'h00;         // Bits taken in this frame
    logic [31:0] word_q    = 32'h0000_0000; // Last complete frame
    logic        toggle_q  = 1'b0;          // Frame event flag

    assign frame_word_o   = word_q;
    assign frame_toggle_o = toggle_q;

    wire         last_bit = (bit_count == 5'(FRAME_BITS - 1));

    // Select high restarts the count; the next frame follows at bit 33
    always_ff @(posedge serial_clk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            bit_count <= 5'h00;
        end else begin
            bit_count <= last_bit ? 5'h00 : bit_count + 5'h01;
        end
    end

    // Data capture; word and toggle stand until the next full frame
    always_ff @(posedge serial_clk_i) begin
        if (!serial_select_n_i) begin
            shift <= {shift[29:0], serial_write_input_i};
            if (last_bit) begin
                word_q   <= {shift, serial_write_input_i};
                toggle_q <= ~toggle_q;
            end
        end
    end

endmodule

// ---- hdl/adc_trim_interleave_regs.sv ----
// Trim and interleave control register bank written over a serial port.
// Assumes the host obeys frame format; system clock runs at 100 MHz.
`timescale 1ns/1ps
module adc_trim_interleave_regs
    import trim_regs_pkg::*;
(
    input  wire logic        clk_sys_i,          // System clock
    input  wire logic        reset_n_i,          // Sync reset, low active
    input  wire logic        serial_clk_i,       // Host serial clock
    input  wire logic        serial_select_n_i,  // Frame select, low
    input  wire logic        serial_write_input_i, // Serial data
    input  wire logic        extended_mode_i,    // Extended control mode
    output logic [7:0]       ch1_offset_mag_o,   // First channel offset
    output logic             ch1_offset_neg_o,   // First offset negative
    output logic [8:0]       ch1_gain_code_o,    // First channel gain
    output logic [7:0]       ch2_offset_mag_o,   // Second channel offset
    output logic             ch2_offset_neg_o,   // Second offset negative
    output logic [8:0]       ch2_gain_code_o,    // Second channel gain
    output logic             interleave_on_o,    // Dual-edge sampling
    output logic             auto_phase_ctrl_o,  // Phase detector on
    output logic             shared_input_choice_o, // Shared input pick
    output logic             skew_target_choice_o,  // Delayed clock pick
    output logic [2:0]       coarse_skew_code_o, // Coarse delay code
    output logic [8:0]       fine_skew_code_o    // Fine delay code
);

    // ------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------
    logic [31:0] frame_word;    // Held in link domain until next frame
    logic        frame_toggle;  // Event flag in link domain

    frame_shifter u_shifter (
        .serial_clk_i         (serial_clk_i),
        .serial_select_n_i    (serial_select_n_i),
        .serial_write_input_i (serial_write_input_i),
        .frame_word_o         (frame_word),
        .frame_toggle_o       (frame_toggle)
    );

    // ------------------------------------------------------------------
    // Toggle crossing
    // ------------------------------------------------------------------
    logic       tog_meta;    // First synchroniser stage, read by tog_sync
    logic       tog_sync;    // Second stage
    logic       tog_seen;    // Last handled toggle level

    // Plain two-stage synchroniser plus an edge memory
    always_ff @(posedge clk_sys_i) begin
        tog_meta <= frame_toggle;
        tog_sync <= tog_meta;
        tog_seen <= tog_sync;
    end

    // The word is stable for many system cycles once the toggle arrives,
    // since a new frame takes 32 serial clocks of 30 ns each.
    wire        frame_event = tog_sync ^ tog_seen;

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    logic [31:0] word_hold;  // Frame word sampled one cycle after event
    logic        word_valid; // Pulse with word_hold

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            word_valid <= 1'b0;
            word_hold  <= 32'h0000_0000;
        end else begin
            word_valid <= frame_event;
            if (frame_event) begin
                word_hold <= frame_word;
            end
        end
    end

    wire        header_ok = (word_hold[HDR_MSB:HDR_LSB] == FRAME_HEADER);
    wire [3:0]  wr_addr   = word_hold[ADDR_MSB:ADDR_LSB];
    wire [15:0] wr_data   = word_hold[15:0];
    wire        wr_go     = word_valid & header_ok;

    // Address strobes; reserved and configuration addresses match none
    wire        we_ch1_ofs  = wr_go & (wr_addr == ADDR_CH1_OFFSET);
    wire        we_ch1_gain = wr_go & (wr_addr == ADDR_CH1_GAIN);
    wire        we_ch2_ofs  = wr_go & (wr_addr == ADDR_CH2_OFFSET);
    wire        we_ch2_gain = wr_go & (wr_addr == ADDR_CH2_GAIN);
    wire        we_ilv_en   = wr_go & (wr_addr == ADDR_ILV_ENABLE);
    wire        we_coarse   = wr_go & (wr_addr == ADDR_ILV_COARSE);
    wire        we_fine     = wr_go & (wr_addr == ADDR_ILV_FINE);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Whole words are stored; unused bits are kept but steer nothing,
    // so a host that forgets the fill ones does no harm here.
    logic [15:0] ch1_offset_trim;
    logic [15:0] ch1_gain_trim;
    logic [15:0] ch2_offset_trim;
    logic [15:0] ch2_gain_trim;
    logic [15:0] interleave_enable_ctrl;
    logic [15:0] interleave_coarse_skew;
    logic [15:0] interleave_fine_skew;

    // Offset registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ch1_offset_trim <= RST_OFFSET;
            ch2_offset_trim <= RST_OFFSET;
        end else begin
            if (we_ch1_ofs) ch1_offset_trim <= wr_data;
            if (we_ch2_ofs) ch2_offset_trim <= wr_data;
        end
    end

    // Gain registers; applied at once, no recalibration step
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ch1_gain_trim <= RST_GAIN;
            ch2_gain_trim <= RST_GAIN;
        end else begin
            if (we_ch1_gain) ch1_gain_trim <= wr_data;
            if (we_ch2_gain) ch2_gain_trim <= wr_data;
        end
    end

    // Interleave registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            interleave_enable_ctrl <= RST_ILV_ENABLE;
            interleave_coarse_skew <= RST_ILV_COARSE;
            interleave_fine_skew   <= RST_ILV_FINE;
        end else begin
            if (we_ilv_en) interleave_enable_ctrl <= wr_data;
            if (we_coarse) interleave_coarse_skew <= wr_data;
            if (we_fine)   interleave_fine_skew   <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Extended-mode gating
    // ------------------------------------------------------------------
    // Outside extended mode every control shows its reset meaning.
    logic        mode_meta;  // Pin synchroniser, first stage
    logic        mode_ext;   // Synchronised extended-mode level

    always_ff @(posedge clk_sys_i) begin
        mode_meta <= extended_mode_i;
        mode_ext  <= mode_meta;
    end

    wire [15:0] eff_ch1_ofs  = mode_ext ? ch1_offset_trim : RST_OFFSET;
    wire [15:0] eff_ch2_ofs  = mode_ext ? ch2_offset_trim : RST_OFFSET;
    wire [15:0] eff_ch1_gain = mode_ext ? ch1_gain_trim : RST_GAIN;
    wire [15:0] eff_ch2_gain = mode_ext ? ch2_gain_trim : RST_GAIN;
    wire [15:0] eff_ilv_en   = mode_ext ? interleave_enable_ctrl
                                        : RST_ILV_ENABLE;
    wire [15:0] eff_coarse   = mode_ext ? interleave_coarse_skew
                                        : RST_ILV_COARSE;
    wire [15:0] eff_fine     = mode_ext ? interleave_fine_skew
                                        : RST_ILV_FINE;

    // Automatic phase control forces manual skew to zero
    wire        auto_phase   = eff_ilv_en[AUTO_PHASE_BIT];
    wire [2:0]  next_coarse  = auto_phase ? 3'h0
                             : eff_coarse[COARSE_MSB:COARSE_LSB];
    wire [8:0]  next_fine    = auto_phase ? 9'h000
                             : eff_fine[FINE_MSB:FINE_LSB];

    // Offset magnitudes picked out of the stored words
    wire [7:0]  ch1_mag      = eff_ch1_ofs[OFS_MAG_MSB:OFS_MAG_LSB];
    wire [7:0]  ch2_mag      = eff_ch2_ofs[OFS_MAG_MSB:OFS_MAG_LSB];

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Polarity is carried separately even at zero magnitude, because
    // the analog side gives plus zero and minus zero distinct levels.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ch1_offset_mag_o <= 8'h00;
            ch1_offset_neg_o <= 1'b0;
            ch2_offset_mag_o <= 8'h00;
            ch2_offset_neg_o <= 1'b0;
        end else begin
            ch1_offset_mag_o <= ch1_mag;
            ch1_offset_neg_o <= eff_ch1_ofs[OFS_SIGN_BIT];
            ch2_offset_mag_o <= ch2_mag;
            ch2_offset_neg_o <= eff_ch2_ofs[OFS_SIGN_BIT];
        end
    end

    // Gain codes
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ch1_gain_code_o <= RST_GAIN[GAIN_MSB:GAIN_LSB];
            ch2_gain_code_o <= RST_GAIN[GAIN_MSB:GAIN_LSB];
        end else begin
            ch1_gain_code_o <= eff_ch1_gain[GAIN_MSB:GAIN_LSB];
            ch2_gain_code_o <= eff_ch2_gain[GAIN_MSB:GAIN_LSB];
        end
    end

    // Interleave controls
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            interleave_on_o       <= 1'b0;
            auto_phase_ctrl_o     <= 1'b0;
            shared_input_choice_o <= 1'b0;
            skew_target_choice_o  <= 1'b0;
            coarse_skew_code_o    <= 3'h0;
            fine_skew_code_o      <= 9'h000;
        end else begin
            interleave_on_o       <= eff_ilv_en[ILV_ON_BIT];
            auto_phase_ctrl_o     <= auto_phase;
            shared_input_choice_o <= eff_coarse[INPUT_SEL_BIT];
            skew_target_choice_o  <= eff_coarse[SKEW_SEL_BIT];
            coarse_skew_code_o    <= next_coarse;
            fine_skew_code_o      <= next_fine;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_manual_skew;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_ext && !auto_phase) |=>
            (coarse_skew_code_o == $past(interleave_coarse_skew[13:11]));
    endproperty
    a_manual_skew: assert property (p_manual_skew)
        else $error("Coarse skew differs from register");

    property p_auto_zero;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        auto_phase_ctrl_o |-> (coarse_skew_code_o == 3'h0
                               && fine_skew_code_o == 9'h000);
    endproperty
    a_auto_zero: assert property (p_auto_zero)
        else $error("Manual skew active under auto phase");

    sequence s_gain_write;
        we_ch1_gain && mode_ext ##1 mode_ext;
    endsequence
    property p_gain_apply;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        s_gain_write |=> (ch1_gain_code_o == $past(wr_data[15:7], 2));
    endproperty
    a_gain_apply: assert property (p_gain_apply)
        else $error("Gain write not applied");

    property p_normal_mode;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!mode_ext) [*2] |-> (!interleave_on_o && ch1_gain_code_o == 9'h100);
    endproperty
    a_normal_mode: assert property (p_normal_mode)
        else $error("Trim active outside extended mode");

    property p_bad_header;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (word_valid && !header_ok) |=> $stable(ch1_offset_trim)
            && $stable(interleave_enable_ctrl);
    endproperty
    a_bad_header: assert property (p_bad_header)
        else $error("Register changed by bad header");

    property p_sign;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        mode_ext |=> (ch2_offset_neg_o == $past(ch2_offset_trim[7]));
    endproperty
    a_sign: assert property (p_sign)
        else $error("Offset polarity mismatch");

    property p_offset_mag;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        mode_ext |=> (ch1_offset_mag_o == $past(ch1_offset_trim[15:8]));
    endproperty
    a_offset_mag: assert property (p_offset_mag)
        else $error("Offset magnitude mismatch");

    property p_event_latency;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_event |=> word_valid ##1 !word_valid;
    endproperty
    a_event_latency: assert property (p_event_latency)
        else $error("Frame event not decoded once");

endmodule

// ---- verification/serial_host_model.sv ----
// Host model that writes frames over the three-wire serial port.
// Assumes the bench calls send; the link clock is still between frames.
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clk_o,      // Link clock, idle low, 30 ns period
    output logic serial_select_n_o, // Frame select, low active
    output logic serial_data_o      // Serial data, MSB first
);
    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    initial begin
        serial_clk_o      = 1'b0;
        serial_select_n_o = 1'b1;
        serial_data_o     = 1'b0;
    end

    // ------------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------------
    // Data changes after a falling edge and is held across the rising
    // edge; keep leaves select low so the next frame starts at once
    task automatic send(input logic [31:0] word, input int nbits,
                        input bit keep);
        int i;
        #7 serial_select_n_o = 1'b0; // Odd delay keeps phase unrelated
        for (i = 31; i > 31 - nbits; i--) begin
            serial_data_o = word[i];
            #15 serial_clk_o = 1'b1;
            #15 serial_clk_o = 1'b0;
        end
        if (!keep) begin
            #15 serial_select_n_o = 1'b1;
            // A released line must not look like a held bit
            serial_data_o = ~serial_data_o;
        end
    endtask
endmodule

// ---- verification/test_adc_trim_interleave_regs.sv ----
// Self-checking bench for the trim register bank.
// Assumes the serial host model drives the link; no read back exists.
`timescale 1ns/1ps
module test_adc_trim_interleave_regs;
    import trim_regs_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk_sys_i = 1'b0; // 100 MHz system clock
    logic        reset_n_i = 1'b0; // Held low at start
    logic        ext_mode  = 1'b1; // Extended control mode
    wire         sclk, ssel_n, serial_write_input;
    logic [7:0]  ofs1, ofs2;
    logic        neg1, neg2, ilv, auto_phase_ctrl, insel, skewsel;
    logic [8:0]  gain1, gain2, fine;
    logic [2:0]  coarse;
    logic [15:0] shadow [16];       // Expected register images
    bit          ext_exp = 1'b1;    // Expected mode seen by the design
    int          fail_count = 0, checked = 0, cycles = 0;
    // Written values keep ones in every unused bit, gains in band
    logic [3:0]  addr_tab [7] = '{ADDR_CH1_OFFSET, ADDR_CH1_GAIN,
        ADDR_CH2_OFFSET, ADDR_CH2_GAIN, ADDR_ILV_ENABLE,
        ADDR_ILV_COARSE, ADDR_ILV_FINE};
    logic [15:0] data_tab [7] = '{16'h00FF, 16'hE07F, 16'hFF7F,
        16'h607F, 16'hBFFF, 16'hD7FF, 16'hAAFF};

    always #5 clk_sys_i = ~clk_sys_i;

    serial_host_model host (.serial_clk_o(sclk),
        .serial_select_n_o(ssel_n), .serial_data_o(serial_write_input));

    adc_trim_interleave_regs DUT (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .serial_clk_i(sclk),
        .serial_select_n_i(ssel_n), .serial_write_input_i(serial_write_input),
        .extended_mode_i(ext_mode), .ch1_offset_mag_o(ofs1),
        .ch1_offset_neg_o(neg1), .ch1_gain_code_o(gain1),
        .ch2_offset_mag_o(ofs2), .ch2_offset_neg_o(neg2),
        .ch2_gain_code_o(gain2), .interleave_on_o(ilv),
        .auto_phase_ctrl_o(auto_phase_ctrl), .shared_input_choice_o(insel),
        .skew_target_choice_o(skewsel), .coarse_skew_code_o(coarse),
        .fine_skew_code_o(fine));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] rst_of(input logic [3:0] a);
        case (a)
            ADDR_CH1_GAIN, ADDR_CH2_GAIN: return RST_GAIN;
            ADDR_ILV_ENABLE:              return RST_ILV_ENABLE;
            ADDR_ILV_COARSE:              return RST_ILV_COARSE;
            ADDR_ILV_FINE:                return RST_ILV_FINE;
            default:                      return RST_OFFSET;
        endcase
    endfunction

    // Normal mode shows reset meaning, stored contents are kept
    function automatic logic [15:0] view(input logic [3:0] a);
        return ext_exp ? shadow[a] : rst_of(a);
    endfunction

    // Only a good header to a mapped address may change the image
    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input bit keep = 0, input logic [11:0] h = 12'h001);
        host.send({h, a, d}, 32, keep);
        for (int k = 0; k < 7; k++) begin
            if (h === FRAME_HEADER && a === addr_tab[k]) begin
                shadow[a] = d;
            end
        end
    endtask

    // Outputs settle within six cycles; twelve leaves margin
    task automatic verify(input string name);
        logic [15:0] o1, g1, o2, g2, e, c, f;
        repeat (12) @(negedge clk_sys_i);
        o1 = view(ADDR_CH1_OFFSET);
        g1 = view(ADDR_CH1_GAIN);
        o2 = view(ADDR_CH2_OFFSET);
        g2 = view(ADDR_CH2_GAIN);
        e  = view(ADDR_ILV_ENABLE);
        c  = view(ADDR_ILV_COARSE);
        f  = view(ADDR_ILV_FINE);
        check(16'(ofs1), 16'(o1[OFS_MAG_MSB:OFS_MAG_LSB]));
        check(16'(neg1), 16'(o1[OFS_SIGN_BIT]));
        check(16'(gain1), 16'(g1[GAIN_MSB:GAIN_LSB]));
        check(16'(ofs2), 16'(o2[OFS_MAG_MSB:OFS_MAG_LSB]));
        check(16'(neg2), 16'(o2[OFS_SIGN_BIT]));
        check(16'(gain2), 16'(g2[GAIN_MSB:GAIN_LSB]));
        check(16'(ilv), 16'(e[ILV_ON_BIT]));
        check(16'(auto_phase_ctrl), 16'(e[AUTO_PHASE_BIT]));
        check(16'(insel), 16'(c[INPUT_SEL_BIT]));
        check(16'(skewsel), 16'(c[SKEW_SEL_BIT]));
        check(16'(coarse), e[14] ? 16'h0000 : 16'(c[13:11]));
        check(16'(fine), e[14] ? 16'h0000 : 16'(f[15:7]));
        $display("test %s done", name);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cut a hang short well beyond the few thousand cycles expected
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        for (int a = 0; a < 16; a++) shadow[a] = rst_of(4'(a));
        repeat (5) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        verify("reset values");
        for (int i = 0; i < 7; i++) begin
            wr(addr_tab[i], data_tab[i]);
            verify("register write");
        end
        wr(ADDR_CH1_OFFSET, 16'h017F, 1);
        wr(ADDR_CH1_GAIN, 16'h807F);
        verify("back to back");
        wr(ADDR_CH2_OFFSET, 16'h127F, 0, 12'h003);
        // Reserved and configuration addresses only; fill ones kept
        for (int a = 4; a < 10; a++) wr(4'(a), 16'h5A7F);
        wr(4'h1, 16'hB2FF);
        wr(4'h0, 16'h337F);
        wr(4'hC, 16'h337F);
        verify("refused frames");
        host.send({FRAME_HEADER, ADDR_CH2_GAIN, 16'h707F}, 31, 0);
        wr(ADDR_CH2_OFFSET, 16'h20FF);
        verify("aborted frame");
        wr(ADDR_ILV_ENABLE, 16'h7FFF);
        verify("auto phase");
        wr(ADDR_ILV_ENABLE, 16'hBFFF);
        verify("manual skew");
        ext_mode = 1'b0;
        ext_exp  = 1'b0;
        verify("normal mode");
        ext_mode = 1'b1;
        ext_exp  = 1'b1;
        verify("extended again");
        reset_n_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        for (int a = 0; a < 16; a++) shadow[a] = rst_of(4'(a));
        verify("second reset");
        conclude();
    end
endmodule
